// ---- rtl/supervisor_pkg.sv ----
// constants, types and period decoding shared by the supervisor watchdog and chip-select gate
package supervisor_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and timing figures
    localparam int CLK_PERIOD_NS = 20;
    localparam int KICK_MIN_NS   = 100;
    localparam int CE_HOLD_NS    = 12000;
    localparam int TICK_NS       = 1000000;
    localparam int KICK_W        = 3;
    localparam int CE_W          = 10;
    localparam int CNT_W         = 13;
    // least time rounds up, longest time rounds down
    localparam logic [KICK_W-1:0] KICK_MIN_CYC = KICK_W'((KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CE_W-1:0]   CE_HOLD_CYC  = CE_W'(CE_HOLD_NS / CLK_PERIOD_NS);
    localparam int                TICK_CYC     = TICK_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // periods in ticks: internal tick is one millisecond, external tick is one clock
    localparam logic [CNT_W-1:0] WD_FAST_MS  = 13'h0064;
    localparam logic [CNT_W-1:0] WD_SLOW_MS  = 13'h0640;
    localparam logic [CNT_W-1:0] RST_MS      = 13'h00c8;
    localparam logic [CNT_W-1:0] EXT_WD_CLK  = 13'h0400;
    localparam logic [CNT_W-1:0] EXT_1ST_CLK = 13'h1000;
    localparam logic [CNT_W-1:0] EXT_RST_CLK = 13'h0800;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {TB_EXTERNAL, TB_FAST, TB_SLOW} timebase_e;
    typedef enum logic [1:0] {ST_SUPPLY_LOW, ST_RESET_HOLD, ST_WATCH} wd_state_e;

    // comparator results and pin levels; a floating select or timebase pin reads high
    typedef struct packed {
        logic supply_below_thresh;
        logic supply_below_backup;
        logic early_warn_below;
        logic kick_high;
        logic kick_mid;
        logic timebase_select;
        logic timebase_input;
        logic ce_in_n;
    } pins_s;

    typedef struct packed {
        logic reset_n;
        logic reset;
        logic reset_oe;
        logic fault_n;
        logic supply_low_n;
        logic early_warn_n;
        logic backup_active;
        logic ce_out_n;
        logic ce_pullup;
    } outs_s;

    ////////////////////////////////////////////////////////////////////////////////
    // period length in ticks for a timebase, for the watchdog (first or normal) or the reset hold
    function automatic logic [CNT_W-1:0] period_limit(timebase_e mode, logic first, logic hold);
        logic [CNT_W-1:0] lim;
        lim = WD_SLOW_MS;
        case (mode)
            TB_EXTERNAL: lim = hold ? EXT_RST_CLK : (first ? EXT_1ST_CLK : EXT_WD_CLK);
            TB_FAST:     lim = hold ? RST_MS : (first ? WD_SLOW_MS : WD_FAST_MS);
            TB_SLOW:     lim = hold ? RST_MS : WD_SLOW_MS;
            default:     lim = hold ? RST_MS : WD_SLOW_MS;
        endcase
        return lim;
    endfunction

endpackage

// ---- rtl/supervisor_watchdog_ce_gate.sv ----
// supervisor core: watchdog, reset pulse, chip-select gate and backup-mode output control
//
// Contract
// - host toggles kick, each level held 100ns; each qualified change restarts watchdog
// - kick at floating mid level disables watchdog, no timeout raised
// - supply below threshold: watchdog off, kick ignored, fault output high
// - missed kick: both resets for reset timeout, fault low until next kick
// - constant kick gives repeated reset pulses, each after a first watchdog period
// - external clock timebase: 1024 normal, 4096 first, 2048 reset cycles
// - select high, timebase low: 100ms normal, 1.6s first, 200ms reset
// - select and timebase high: 1.6s watchdog period, 200ms reset timeout
// - chip-select passes through normally, path disabled during reset once the gate closes
// - power-down: gate closes when chip-select goes high or 12us after reset
// - power-up: gate stays closed until reset is deasserted
// - closed gate drives chip-select output high; drive released when gate opens
// - supply-low output is low while supply below threshold, else high
// - early-warning output low when input below 1.25V; affects nothing else
// - backup mode only when supply below both threshold and backup supply
// - backup-active output high when supply below backup supply, else low
// - backup mode: low/reset/warning low, fault/chip-select high, reset undriven
// - resets asserted while supply low and for reset timeout after it recovers
// - kick is a three-level input: high, low and floating mid
`timescale 1ns/1ns
module supervisor_watchdog_ce_gate #(
    parameter int TICK_CYCLES = supervisor_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    // comparator results and pin levels
    input  wire supervisor_pkg::pins_s pins_i,
    // reset outputs
    output logic                       reset_n_o,
    output logic                       reset_o,
    output logic                       reset_oe_o,
    // status outputs
    output logic                       watchdog_fault_n_o,
    output logic                       supply_low_n_o,
    output logic                       early_warn_out_n_o,
    output logic                       backup_active_o,
    // chip-select gate
    output logic                       ce_out_n_o,
    output logic                       ce_pullup_o
);

    localparam int DIV_W = $clog2(TICK_CYCLES);

    generate
        if (TICK_CYCLES < 2) begin : g_bad_tick
            $error("TICK_CYCLES must be at least 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    supervisor_pkg::pins_s sync1_reg;
    supervisor_pkg::pins_s sync2_reg;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins_i;
            sync2_reg <= sync1_reg;
        end
    end

    logic sup_low;
    logic backup;
    assign sup_low = sync2_reg.supply_below_thresh;
    assign backup  = sync2_reg.supply_below_thresh & sync2_reg.supply_below_backup;

    ////////////////////////////////////////////////////////////////////////////////
    // kick level qualifier: a level counts only after it has stood for the minimum time
    logic [1:0]                      cand_reg;
    logic [1:0]                      cand_next;
    logic [1:0]                      acc_reg;
    logic [1:0]                      acc_next;
    logic [supervisor_pkg::KICK_W-1:0] stab_reg;
    logic [supervisor_pkg::KICK_W-1:0] stab_next;
    logic                            kick_evt_reg;
    logic                            kick_evt_next;
    logic [1:0]                      kick_lvl;
    logic                            kick_mid;

    // mid level decoded ahead of high/low
    assign kick_lvl = sync2_reg.kick_mid ? 2'h2 : {1'b0, sync2_reg.kick_high};
    assign kick_mid = acc_reg[1];

    always_comb begin
        cand_next     = cand_reg;
        stab_next     = stab_reg;
        acc_next      = acc_reg;
        kick_evt_next = 1'b0;
        if (kick_lvl != cand_reg) begin
            cand_next = kick_lvl;
            stab_next = '0;
        end else if (stab_reg < supervisor_pkg::KICK_MIN_CYC - 3'h1) begin
            stab_next = stab_reg + 3'h1;
        end else if (cand_reg != acc_reg) begin
            acc_next      = cand_reg;
            kick_evt_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cand_reg     <= 2'h2;
            acc_reg      <= 2'h2;
            stab_reg     <= '0;
            kick_evt_reg <= 1'b0;
        end else begin
            cand_reg     <= cand_next;
            acc_reg      <= acc_next;
            stab_reg     <= stab_next;
            kick_evt_reg <= kick_evt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timebase: millisecond divider, or rising edges of the external clock
    supervisor_pkg::timebase_e mode;
    logic [DIV_W-1:0]          div_reg;
    logic [DIV_W-1:0]          div_next;
    logic                      tb_prev_reg;
    logic                      tick_reg;
    logic                      tick_next;

    // select low means external clock; select high picks fast or slow
    assign mode = !sync2_reg.timebase_select ? supervisor_pkg::TB_EXTERNAL :
                  (sync2_reg.timebase_input ? supervisor_pkg::TB_SLOW : supervisor_pkg::TB_FAST);

    always_comb begin
        div_next  = (div_reg == DIV_W'(TICK_CYCLES - 1)) ? '0 : div_reg + DIV_W'(1);
        tick_next = 1'b0;
        if (!backup) begin
            if (mode == supervisor_pkg::TB_EXTERNAL) begin
                tick_next = sync2_reg.timebase_input & ~tb_prev_reg;
            end else begin
                tick_next = (div_reg == DIV_W'(TICK_CYCLES - 1));
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            div_reg     <= '0;
            tb_prev_reg <= 1'b0;
            tick_reg    <= 1'b0;
        end else begin
            div_reg     <= div_next;
            tb_prev_reg <= sync2_reg.timebase_input;
            tick_reg    <= tick_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog and reset sequencer
    supervisor_pkg::wd_state_e       state_reg;
    supervisor_pkg::wd_state_e       state_next;
    logic [supervisor_pkg::CNT_W-1:0] cnt_reg;
    logic [supervisor_pkg::CNT_W-1:0] cnt_next;
    logic [supervisor_pkg::CNT_W-1:0] wd_lim;
    logic [supervisor_pkg::CNT_W-1:0] rst_lim;
    logic                            first_reg;
    logic                            first_next;
    logic                            fault_reg;
    logic                            fault_next;
    logic                            wd_expire;

    assign wd_lim    = supervisor_pkg::period_limit(mode, first_reg, 1'b0);
    assign rst_lim   = supervisor_pkg::period_limit(mode, 1'b0, 1'b1);
    assign wd_expire = (state_reg == supervisor_pkg::ST_WATCH) && !sup_low && !kick_mid &&
                       !kick_evt_reg && tick_reg && (cnt_reg == wd_lim - 13'h0001);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        first_next = first_reg;
        fault_next = fault_reg;
        if (sup_low) begin
            // held in reset, watchdog off, fault high
            state_next = supervisor_pkg::ST_SUPPLY_LOW;
            cnt_next   = '0;
            first_next = 1'b1;
            fault_next = 1'b1;
        end else begin
            // fault stays low until the next kick change; open kick reads high
            if (kick_evt_reg || kick_mid) begin
                fault_next = 1'b1;
            end
            case (state_reg)
                supervisor_pkg::ST_SUPPLY_LOW: begin
                    state_next = supervisor_pkg::ST_RESET_HOLD;
                    cnt_next   = '0;
                end
                supervisor_pkg::ST_RESET_HOLD: begin
                    // reset held for the reset timeout, then a first period starts
                    if (tick_reg) begin
                        if (cnt_reg == rst_lim - 13'h0001) begin
                            state_next = supervisor_pkg::ST_WATCH;
                            cnt_next   = '0;
                            first_next = 1'b1;
                        end else begin
                            cnt_next = cnt_reg + 13'h0001;
                        end
                    end
                end
                supervisor_pkg::ST_WATCH: begin
                    if (kick_mid) begin
                        cnt_next = '0;
                    end else if (kick_evt_reg) begin
                        cnt_next   = '0;
                        first_next = 1'b0;
                    end else if (wd_expire) begin
                        state_next = supervisor_pkg::ST_RESET_HOLD;
                        cnt_next   = '0;
                        fault_next = 1'b0;
                    end else if (tick_reg) begin
                        cnt_next = cnt_reg + 13'h0001;
                    end
                end
                default: begin
                    state_next = supervisor_pkg::ST_SUPPLY_LOW;
                    cnt_next   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= supervisor_pkg::ST_SUPPLY_LOW;
            cnt_reg   <= '0;
            first_reg <= 1'b1;
            fault_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            first_reg <= first_next;
            fault_reg <= fault_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // chip-select gate; the path goes through the synchronisers, so it lags by three cycles
    logic                          rst_act_next;
    logic                          gate_reg;
    logic                          gate_next;
    logic [supervisor_pkg::CE_W-1:0] ce_cnt_reg;
    logic [supervisor_pkg::CE_W-1:0] ce_cnt_next;

    assign rst_act_next = (state_next != supervisor_pkg::ST_WATCH);

    always_comb begin
        ce_cnt_next = '0;
        gate_next   = 1'b1;
        if (rst_act_next) begin
            ce_cnt_next = (ce_cnt_reg == supervisor_pkg::CE_HOLD_CYC) ? ce_cnt_reg : ce_cnt_reg + 10'h001;
            // close on chip-select high or after the hold time; stays closed
            gate_next   = gate_reg && !sync2_reg.ce_in_n && (ce_cnt_reg != supervisor_pkg::CE_HOLD_CYC);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            gate_reg   <= 1'b0;
            ce_cnt_reg <= '0;
        end else begin
            gate_reg   <= gate_next;
            ce_cnt_reg <= ce_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output registers
    supervisor_pkg::outs_s out_reg;
    supervisor_pkg::outs_s out_next;

    always_comb begin
        out_next.reset_n       = !rst_act_next;
        out_next.reset         = rst_act_next;
        out_next.reset_oe      = 1'b1;
        out_next.fault_n       = fault_next;
        out_next.supply_low_n  = !sup_low;
        // warning comparator only drives its own output
        out_next.early_warn_n  = !sync2_reg.early_warn_below;
        out_next.backup_active = sync2_reg.supply_below_backup;
        out_next.ce_out_n      = gate_next ? sync2_reg.ce_in_n : 1'b1;
        out_next.ce_pullup     = !gate_next;
        if (backup) begin
            out_next.reset_n      = 1'b0;
            out_next.reset_oe     = 1'b0;
            out_next.fault_n      = 1'b1;
            out_next.early_warn_n = 1'b0;
            out_next.ce_out_n     = 1'b1;
            out_next.ce_pullup    = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            out_reg <= '{reset_n: 1'b0, reset: 1'b1, reset_oe: 1'b1, fault_n: 1'b1, supply_low_n: 1'b1,
                         early_warn_n: 1'b1, backup_active: 1'b0, ce_out_n: 1'b1, ce_pullup: 1'b1};
        end else begin
            out_reg <= out_next;
        end
    end

    assign reset_n_o          = out_reg.reset_n;
    assign reset_o            = out_reg.reset;
    assign reset_oe_o         = out_reg.reset_oe;
    assign watchdog_fault_n_o = out_reg.fault_n;
    assign supply_low_n_o     = out_reg.supply_low_n;
    assign early_warn_out_n_o = out_reg.early_warn_n;
    assign backup_active_o    = out_reg.backup_active;
    assign ce_out_n_o         = out_reg.ce_out_n;
    assign ce_pullup_o        = out_reg.ce_pullup;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence timeout_s;
        wd_expire ##1 (state_reg == supervisor_pkg::ST_RESET_HOLD);
    endsequence
    sequence pulse_out_s;
        !reset_n_o && reset_o && !watchdog_fault_n_o;
    endsequence

    kick_restart_a: assert property ((state_reg == supervisor_pkg::ST_WATCH) && kick_evt_reg && !sup_low
        && !kick_mid |=> cnt_reg == '0 && !first_reg) else $error("kick did not restart watchdog");
    mid_disable_a: assert property ((state_reg == supervisor_pkg::ST_WATCH) && kick_mid && !sup_low
        |=> state_reg == supervisor_pkg::ST_WATCH && cnt_reg == '0) else $error("watchdog ran with kick open");
    low_fault_a: assert property (sup_low |=> watchdog_fault_n_o && !reset_n_o && cnt_reg == '0)
        else $error("supply low without fault high and reset");
    timeout_pulse_a: assert property (timeout_s and (!backup ##1 1'b1) |-> pulse_out_s)
        else $error("timeout gave no reset pulse");
    hold_end_a: assert property ((state_reg == supervisor_pkg::ST_RESET_HOLD) && !sup_low && tick_reg
        && cnt_reg == rst_lim - 13'h0001 |=> state_reg == supervisor_pkg::ST_WATCH && first_reg && reset_n_o)
        else $error("reset hold ended wrongly");
    // expiry must land on the documented count, whatever the period decoder says
    ext_first_a: assert property ((state_reg == supervisor_pkg::ST_WATCH) && first_reg && tick_reg
        && !sup_low && !kick_mid && !kick_evt_reg && mode == supervisor_pkg::TB_EXTERNAL
        && cnt_reg == supervisor_pkg::EXT_1ST_CLK - 13'h0001 |=> !reset_n_o)
        else $error("external first period wrong");
    fast_normal_a: assert property ((state_reg == supervisor_pkg::ST_WATCH) && !first_reg && tick_reg
        && !sup_low && !kick_mid && !kick_evt_reg && mode == supervisor_pkg::TB_FAST
        && cnt_reg == supervisor_pkg::WD_FAST_MS - 13'h0001 |=> !reset_n_o)
        else $error("fast watchdog period wrong");
    gate_hold_a: assert property (rst_act_next && ce_cnt_reg == supervisor_pkg::CE_HOLD_CYC
        |=> ce_pullup_o && ce_out_n_o) else $error("gate open past hold time");
    gate_shut_a: assert property (!ce_pullup_o && (state_reg != supervisor_pkg::ST_WATCH) ##1
        (state_next != supervisor_pkg::ST_WATCH) && sync2_reg.ce_in_n |=> ce_pullup_o)
        else $error("gate not closed");
    pullup_high_a: assert property (ce_pullup_o |-> ce_out_n_o) else $error("closed gate not driving high");
    low_copy_a: assert property (supply_low_n_o == !$past(sup_low)) else $error("supply-low output wrong");
    backup_out_a: assert property (backup |=> !reset_n_o && !reset_oe_o && !supply_low_n_o
        && !early_warn_out_n_o && watchdog_fault_n_o && ce_out_n_o) else $error("backup outputs wrong");

endmodule

// ---- verification/host_kick_model.sv ----
// host-side model: drives the kick level and the memory chip-select request
`timescale 1ns/1ns
module host_kick_model #(
    parameter int HOLD = 40
) (
    // clock
    input  wire logic clk_i,
    // host controls
    input  wire logic run_i,
    input  wire logic float_i,
    input  wire logic cs_req_i,
    // pin levels
    output logic      kick_high_o = 1'b0,
    output logic      kick_mid_o  = 1'b1,
    output logic      ce_in_n_o   = 1'b1
);
    int cnt = 0;

    always @(posedge clk_i) begin
        #2;
        kick_mid_o = float_i;
        ce_in_n_o  = ~cs_req_i;
        cnt        = run_i ? cnt + 1 : 0;
        if (float_i) begin
            // released pin carries no meaningful level, so it moves every cycle
            kick_high_o = ~kick_high_o;
        end else if (cnt >= HOLD) begin
            cnt         = 0;
            kick_high_o = ~kick_high_o;
        end
    end
endmodule

// ---- verification/tb_supervisor_watchdog_ce_gate.sv ----
// self-checking bench for the supervisor watchdog and chip-select gate
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_supervisor_watchdog_ce_gate;
    logic                  core_clk_i = 1'b0;
    logic                  reset_i    = 1'b1;
    logic                  thr = 1'b1, bak = 1'b0, ew = 1'b0, sel = 1'b1, tb_level = 1'b0, tbi = 1'b0;
    logic                  div = 1'b0, ext_run = 1'b0, run = 1'b0, flt = 1'b1, cs_req = 1'b0;
    logic                  kh, km, cen;
    logic                  reset_n_o, reset_o, reset_oe_o, fault_n, low_n, warn_n, batt, ce_out_n, ce_pullup;
    supervisor_pkg::pins_s pins;
    int                    num_errors  = 0;
    int                    checks_done = 0;
    int                    n;

    assign pins = {thr, bak, ew, kh, km, sel, tbi, cen};
    always #10 core_clk_i = ~core_clk_i;

    // external timebase: one rising edge every four core cycles
    always @(posedge core_clk_i) begin
        #2;
        div = ~div;
        tbi = ext_run ? (tbi ^ div) : tb_level;
    end

    supervisor_watchdog_ce_gate #(.TICK_CYCLES(4)) u_supervisor_watchdog_ce_gate (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .pins_i(pins), .reset_n_o(reset_n_o),
        .reset_o(reset_o), .reset_oe_o(reset_oe_o), .watchdog_fault_n_o(fault_n),
        .supply_low_n_o(low_n), .early_warn_out_n_o(warn_n), .backup_active_o(batt),
        .ce_out_n_o(ce_out_n), .ce_pullup_o(ce_pullup));

    host_kick_model #(.HOLD(40)) u_host_kick_model (
        .clk_i(core_clk_i), .run_i(run), .float_i(flt), .cs_req_i(cs_req),
        .kick_high_o(kh), .kick_mid_o(km), .ce_in_n_o(cen));

    task automatic step(input int c);
        repeat (c) @(posedge core_clk_i);
        #2;
    endtask

    // counts cycles until the active-low reset shows lvl, giving up at max
    task automatic wait_reset(input logic lvl, input int max, output int cyc);
        cyc = 0;
        while (reset_n_o !== lvl && cyc < max) begin
            step(1);
            cyc++;
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge core_clk_i);
        num_errors++;
        report_and_stop();
    end

    initial begin
        #2;
        step(8);
        reset_i = 1'b0;
        step(20);
        `CHK({reset_n_o, reset_o, low_n, fault_n}, 4'h5)
        cs_req = 1'b1;
        step(10);
        `CHK({ce_out_n, ce_pullup}, 2'h3)
        thr = 1'b0;
        wait_reset(1'b1, 1000, n);
        `CHK(n inside {[790:815]}, 1'b1)
        step(5);
        `CHK({ce_out_n, ce_pullup, low_n}, 3'h1)
        cs_req = 1'b0;
        step(5);
        `CHK(ce_out_n, 1'b1)
        ew = 1'b1;
        step(5);
        `CHK({warn_n, reset_n_o}, 2'h1)
        ew = 1'b0;
        $display("power-up test done");
        wait_reset(1'b0, 7000, n);
        `CHK({n == 7000, fault_n}, 2'h3)
        flt = 1'b0;
        run = 1'b1;
        wait_reset(1'b0, 8000, n);
        `CHK(n, 8000)
        run = 1'b0;
        wait_reset(1'b0, 600, n);
        `CHK({n inside {[360:420]}, fault_n, reset_o}, 3'h5)
        wait_reset(1'b1, 1000, n);
        `CHK({n inside {[790:815]}, fault_n}, 2'h2)
        wait_reset(1'b0, 7000, n);
        `CHK(n inside {[6385:6415]}, 1'b1)
        run = 1'b1;
        step(60);
        `CHK(fault_n, 1'b1)
        wait_reset(1'b1, 1000, n);
        // slow timebase after a kick: a fast decode would expire after 100 ticks instead
        tb_level = 1'b1;
        step(100);
        run = 1'b0;
        wait_reset(1'b0, 7000, n);
        `CHK(n inside {[6350:6420]}, 1'b1)
        wait_reset(1'b1, 1000, n);
        `CHK(n inside {[790:815]}, 1'b1)
        $display("watchdog test done");
        cs_req = 1'b1;
        step(10);
        thr = 1'b1;
        step(500);
        `CHK({ce_out_n, reset_n_o, low_n, fault_n}, 4'h1)
        step(120);
        `CHK({ce_out_n, ce_pullup}, 2'h3)
        bak = 1'b1;
        step(5);
        `CHK({batt, reset_oe_o, warn_n, low_n, reset_n_o, ce_out_n, fault_n}, 7'h43)
        thr = 1'b0;
        step(5);
        `CHK({batt, reset_oe_o}, 2'h3)
        bak = 1'b0;
        $display("supply test done");
        run = 1'b0;
        sel = 1'b0;
        ext_run = 1'b1;
        thr = 1'b1;
        reset_i = 1'b1;
        step(8);
        reset_i = 1'b0;
        step(10);
        thr = 1'b0;
        wait_reset(1'b1, 9000, n);
        `CHK(n inside {[8180:8215]}, 1'b1)
        wait_reset(1'b0, 17000, n);
        `CHK(n inside {[16370:16400]}, 1'b1)
        wait_reset(1'b1, 9000, n);
        `CHK(n inside {[8180:8210]}, 1'b1)
        run = 1'b1;
        step(2000);
        run = 1'b0;
        wait_reset(1'b0, 5000, n);
        `CHK(n inside {[4040:4110]}, 1'b1)
        step(20);
        `CHK({ce_out_n, ce_pullup}, 2'h0)
        cs_req = 1'b0;
        step(5);
        `CHK({ce_out_n, ce_pullup}, 2'h3)
        $display("external timebase test done");
        report_and_stop();
    end
endmodule
